// >>> rtl/lpvc_pkg.sv
package lpvc_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam real LPVC_CLK_PERIOD_NS   = 5.0;
  localparam real LPVC_MEAS_PERIOD_MS  = 12.5;
  localparam real LPVC_SETTLE_MAX_MS   = 45.0;
  localparam int  LPVC_MEAS_CYCLES     = int'($floor(LPVC_MEAS_PERIOD_MS * 1.0e6
                                                     / LPVC_CLK_PERIOD_NS));
  localparam int  LPVC_SETTLE_CYCLES   = int'($floor(LPVC_SETTLE_MAX_MS * 1.0e6
                                                     / LPVC_CLK_PERIOD_NS));

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] LPVC_OFS_CTRL = 8'h00;
  localparam logic [7:0] LPVC_OFS_VOLT = 8'h04;
  localparam logic [7:0] LPVC_OFS_STAT = 8'h08;

  // Control register fields
  localparam int LPVC_CTRL_PUMP_POS  = 0;
  localparam int LPVC_CTRL_DISP_POS  = 1;
  localparam int LPVC_CTRL_ALLON_POS = 2;
  localparam int LPVC_CTRL_FLIP_POS  = 3;
  localparam int LPVC_CTRL_TC_POS    = 4;
  localparam int LPVC_CTRL_W         = 5;
  localparam logic [4:0] LPVC_CTRL_RST = 5'h00;

  // Voltage register fields
  localparam int LPVC_VOLT_CODE_POS = 0;
  localparam int LPVC_VOLT_BIAS_POS = 8;
  localparam logic [7:0] LPVC_VOLT_CODE_RST = 8'h00;
  localparam logic [2:0] LPVC_VOLT_BIAS_RST = 3'h0;

  // Status register fields
  localparam int LPVC_STAT_VALID_POS = 8;
  localparam logic [7:0] LPVC_FLAG_SET_BYTE = 8'hF0;
  localparam logic [7:0] LPVC_FLAG_CLR_BYTE = 8'h0F;

  // Pump supervision states
  typedef enum logic [2:0] {
    LPVC_PUMP_OFF    = 3'b001,
    LPVC_PUMP_SETTLE = 3'b010,
    LPVC_PUMP_RUN    = 3'b100
  } lpvc_pump_t;

endpackage

// >>> rtl/lpvc_tick_gen.sv
`timescale 1ns/1ps
module lpvc_tick_gen
  import lpvc_pkg::*;
#(
  parameter int PERIOD = LPVC_MEAS_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic restart,
  output logic      tick
);

  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;

  // ************************************************************
  // Divider next state
  // ************************************************************
  always_comb begin
    if (restart || cnt_reg == 32'(PERIOD - 1)) begin
      cnt_next = 32'h0000_0000;
    end else begin
      cnt_next = cnt_reg + 32'h0000_0001;
    end
  end

  // Counter register
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cnt_reg <= 32'h0000_0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // One-cycle pulse at the end of each period
  assign tick = !restart && (cnt_reg == 32'(PERIOD - 1));

endmodule // lpvc_tick_gen

// >>> rtl/lpvc_top.sv
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module lpvc_top
  import lpvc_pkg::*;
#(
  parameter int MEAS_CYCLES   = LPVC_MEAS_CYCLES,
  parameter int SETTLE_CYCLES = LPVC_SETTLE_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        pump_level_ok,
  output logic             charge_pump_on,
  output logic             display_active,
  output logic             all_pixels_on,
  output logic             vertical_flip,
  output logic             temp_coefficient,
  output logic      [7:0]  operating_voltage_code,
  output logic      [2:0]  bias_ratio,
  output logic             pump_voltage_ok,
  output logic             flag_valid
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [4:0]  ctrl_reg,  ctrl_next;
  logic [7:0]  code_reg,  code_next;
  logic [2:0]  bias_reg,  bias_next;
  logic        ack_reg,   ack_next;
  logic [31:0] dat_reg,   dat_next;
  logic        stat_rd_reg, stat_rd_next;
  lpvc_pump_t  state_reg, state_next;
  logic [31:0] settle_reg, settle_next;
  logic        flag_reg,  flag_next;
  logic        valid_reg, valid_next;
  logic        meas_tick;
  logic        settle_done;
  logic        wb_req;

  // Status byte for a given flag value
  function automatic logic [7:0] flag_byte(input logic flag);
    flag_byte = flag ? LPVC_FLAG_SET_BYTE : LPVC_FLAG_CLR_BYTE;
  endfunction

  // ************************************************************
  // Measurement timebase
  // ************************************************************
  lpvc_tick_gen #(
    .PERIOD (MEAS_CYCLES)
  ) u_lpvc_tick_gen (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .restart (state_reg == LPVC_PUMP_OFF),
    .tick    (meas_tick)
  );

  // ************************************************************
  // Wishbone slave
  // ************************************************************
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;

  // Register writes and read data capture
  always_comb begin
    ctrl_next    = ctrl_reg;
    code_next    = code_reg;
    bias_next    = bias_reg;
    ack_next     = wb_req;
    dat_next     = dat_reg;
    stat_rd_next = 1'b0;
    if (wb_req) begin
      if (wb_we_i) begin
        if (wb_adr_i == LPVC_OFS_CTRL && wb_sel_i[0]) begin
          ctrl_next = wb_dat_i[LPVC_CTRL_W-1:0];
        end
        if (wb_adr_i == LPVC_OFS_VOLT && wb_sel_i[0]) begin
          code_next = wb_dat_i[LPVC_VOLT_CODE_POS +: 8];
        end
        if (wb_adr_i == LPVC_OFS_VOLT && wb_sel_i[1]) begin
          bias_next = wb_dat_i[LPVC_VOLT_BIAS_POS +: 3];
        end
        dat_next = 32'h0000_0000;
      end else begin
        unique case (wb_adr_i)
          LPVC_OFS_CTRL: begin
            dat_next = {27'h0000000, ctrl_reg};
          end
          LPVC_OFS_VOLT: begin
            dat_next = {21'h000000, bias_reg, code_reg};
          end
          LPVC_OFS_STAT: begin
            // Whole byte taken from one flag sample
            dat_next     = {23'h000000, valid_reg, flag_byte(flag_reg)};
            stat_rd_next = 1'b1;
          end
          default: begin
            dat_next = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // Bus registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl_reg    <= LPVC_CTRL_RST;
      code_reg    <= LPVC_VOLT_CODE_RST;
      bias_reg    <= LPVC_VOLT_BIAS_RST;
      ack_reg     <= 1'b0;
      dat_reg     <= 32'h0000_0000;
      stat_rd_reg <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      code_reg    <= code_next;
      bias_reg    <= bias_next;
      ack_reg     <= ack_next;
      dat_reg     <= dat_next;
      stat_rd_reg <= stat_rd_next;
    end
  end

  // ************************************************************
  // Pump supervision and flag measurement
  // ************************************************************
  assign settle_done = (state_reg == LPVC_PUMP_SETTLE)
                    && (settle_reg == 32'(SETTLE_CYCLES - 1));

  // Next state, settle timer and flag
  always_comb begin
    state_next  = state_reg;
    settle_next = settle_reg;
    flag_next   = flag_reg;
    valid_next  = valid_reg;
    unique case (state_reg)
      LPVC_PUMP_OFF: begin
        settle_next = 32'h0000_0000;
        flag_next   = 1'b0;
        valid_next  = 1'b0;
        if (ctrl_reg[LPVC_CTRL_PUMP_POS]) begin
          state_next = LPVC_PUMP_SETTLE;
        end
      end
      LPVC_PUMP_SETTLE: begin
        settle_next = settle_reg + 32'h0000_0001;
        if (meas_tick || settle_done) begin
          flag_next = pump_level_ok;
        end
        if (settle_done) begin
          state_next = LPVC_PUMP_RUN;
          valid_next = 1'b1;
        end
      end
      LPVC_PUMP_RUN: begin
        if (meas_tick) begin
          flag_next = pump_level_ok;
        end
      end
      default: begin
        state_next = LPVC_PUMP_OFF;
      end
    endcase
    if (!ctrl_reg[LPVC_CTRL_PUMP_POS]) begin
      state_next = LPVC_PUMP_OFF;
    end
  end

  // Supervision registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_reg  <= LPVC_PUMP_OFF;
      settle_reg <= 32'h0000_0000;
      flag_reg   <= 1'b0;
      valid_reg  <= 1'b0;
    end else begin
      state_reg  <= state_next;
      settle_reg <= settle_next;
      flag_reg   <= flag_next;
      valid_reg  <= valid_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign wb_ack_o               = ack_reg;
  assign wb_dat_o               = dat_reg;
  assign charge_pump_on         = ctrl_reg[LPVC_CTRL_PUMP_POS];
  assign display_active         = ctrl_reg[LPVC_CTRL_DISP_POS];
  assign all_pixels_on          = ctrl_reg[LPVC_CTRL_ALLON_POS];
  assign vertical_flip          = ctrl_reg[LPVC_CTRL_FLIP_POS];
  assign temp_coefficient       = ctrl_reg[LPVC_CTRL_TC_POS];
  assign operating_voltage_code = code_reg;
  assign bias_ratio             = bias_reg;
  assign pump_voltage_ok        = flag_reg;
  assign flag_valid             = valid_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_stat_byte;
    @(posedge clk_sys) disable iff (!rst_b)
      (wb_ack_o && stat_rd_reg) |->
        (wb_dat_o[7:0] == ($past(flag_reg) ? 8'hF0 : 8'h0F));
  endproperty
  a_stat_byte: assert property (p_stat_byte) else $error("status byte malformed");

  property p_byte_whole;
    @(posedge clk_sys) disable iff (!rst_b)
      (wb_ack_o && stat_rd_reg) |->
        (wb_dat_o[7:4] == ~wb_dat_o[3:0]) && (wb_dat_o[7:4] == {4{wb_dat_o[7]}});
  endproperty
  a_byte_whole: assert property (p_byte_whole) else $error("status byte bits mixed");

  property p_flag_only_on_tick;
    @(posedge clk_sys) disable iff (!rst_b)
      ($past(state_reg) != LPVC_PUMP_OFF && $changed(flag_reg)
       && $past(ctrl_reg[LPVC_CTRL_PUMP_POS])) |->
        $past(meas_tick || settle_done);
  endproperty
  a_flag_only_on_tick: assert property (p_flag_only_on_tick)
    else $error("flag changed between measurements");

  property p_tick_samples;
    @(posedge clk_sys) disable iff (!rst_b)
      (meas_tick && state_reg == LPVC_PUMP_RUN && ctrl_reg[LPVC_CTRL_PUMP_POS]) |=>
        (flag_reg == $past(pump_level_ok));
  endproperty
  a_tick_samples: assert property (p_tick_samples)
    else $error("tick did not sample level");

  property p_valid_by_settle;
    @(posedge clk_sys) disable iff (!rst_b)
      (settle_done && ctrl_reg[LPVC_CTRL_PUMP_POS]) |=>
        (flag_valid && state_reg == LPVC_PUMP_RUN && flag_reg == $past(pump_level_ok));
  endproperty
  a_valid_by_settle: assert property (p_valid_by_settle)
    else $error("flag not valid at settle end");

  property p_ack_single;
    @(posedge clk_sys) disable iff (!rst_b)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_single: assert property (p_ack_single) else $error("ack not one cycle");

endmodule // lpvc_top

// >>> testbench/lpvc_pump_model.sv
`timescale 1ns/1ps
module lpvc_pump_model #(
  parameter int RISE = 100
) (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic charge_pump_on,
  input  wire logic fault,
  output logic      pump_level_ok
);
  int ramp_reg;

  // Pump output ramps while enabled; switch-off restarts the ramp
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !charge_pump_on) begin
      ramp_reg <= 0;
    end else if (ramp_reg < RISE) begin
      ramp_reg <= ramp_reg + 1;
    end
  end

  // A commanded fault keeps the level low whatever the ramp says
  assign pump_level_ok = (ramp_reg >= RISE) && !fault;
endmodule // lpvc_pump_model

// >>> testbench/lpvc_top_test.sv
`timescale 1ns/1ps
module lpvc_top_test;
  import lpvc_pkg::*;
  localparam int MEAS   = 50;
  localparam int SETTLE = 180;
  localparam int MS     = 4; // Cycles per scaled millisecond
  logic        clk_sys = 1'b0;
  logic        rst_b   = 1'b0;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic [3:0]  sel     = 4'h0;
  logic [3:0]  wsel    = 4'hF;
  logic [31:0] wdat    = 32'h0;
  logic        fault   = 1'b0;
  logic [31:0] rdat, q;
  logic        ack, lvl, pon, dsp, alo, flp, tco, vok, vld;
  logic [7:0]  code;
  logic [2:0]  bias;
  int          num_errors = 0;
  int          checked = 0;
  int          cyc_cnt = 0;

  // Clock and free-running cycle count
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc_cnt <= cyc_cnt + 1;

  lpvc_top #(.MEAS_CYCLES(MEAS), .SETTLE_CYCLES(SETTLE)) u_lpvc_top (
    .clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .pump_level_ok(lvl), .charge_pump_on(pon),
    .display_active(dsp), .all_pixels_on(alo), .vertical_flip(flp),
    .temp_coefficient(tco), .operating_voltage_code(code), .bias_ratio(bias),
    .pump_voltage_ok(vok), .flag_valid(vld));

  lpvc_pump_model #(.RISE(100)) u_lpvc_pump_model (
    .clk_sys(clk_sys), .rst_b(rst_b), .charge_pump_on(pon), .fault(fault),
    .pump_level_ok(lvl));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= wsel;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    if (ack !== 1'b1) check(32'h0, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic settle2();
    repeat (2) @(posedge clk_sys);
  endtask

  // Set when bits 6..4 are ones and bits 2..1 are zeros
  function automatic logic dec_set(input logic [7:0] b);
    return (b[6:4] === 3'b111) && (b[2:1] === 2'b00);
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    check({pon, dsp, alo, flp, tco, code, bias, vok, vld}, 32'h0);
    wb(1'b0, LPVC_OFS_STAT, 32'h0);
    check(q, 32'h0000000F);
    wb(1'b0, 8'h10, 32'h0);
    check(q, 32'h0);
    wb(1'b1, 8'h0C, 32'h1F);
    wb(1'b1, LPVC_OFS_STAT, 32'h1F0);
    // Only the enabled byte lanes may land
    wsel = 4'h2;
    wb(1'b1, LPVC_OFS_CTRL, 32'h1F);
    wb(1'b1, LPVC_OFS_VOLT, 32'h7FF);
    wsel = 4'hF;
    settle2();
    check({tco, flp, alo, dsp, pon}, 32'h0);
    check({bias, code}, 32'h700);
    wb(1'b0, LPVC_OFS_STAT, 32'h0);
    check(q, 32'h0000000F);
  endtask

  task automatic t_init();
    wb(1'b1, LPVC_OFS_VOLT, 32'h0000059F);
    settle2();
    check({bias, code}, 32'h59F);
    wb(1'b0, LPVC_OFS_VOLT, 32'h0);
    check(q, 32'h0000059F);
    wb(1'b1, LPVC_OFS_CTRL, 32'h16);
    settle2();
    check({tco, flp, alo, dsp, pon}, 32'h16);
    wb(1'b0, LPVC_OFS_CTRL, 32'h0);
    check(q, 32'h00000016);
  endtask

  task automatic t_off();
    wb(1'b1, LPVC_OFS_CTRL, 32'h16);
    settle2();
    check({pon, vok, vld}, 32'h0);
  endtask

  // Enable pump, optionally idle, then poll every scaled millisecond
  task automatic t_poll(input int pre, input int limit, input logic exp);
    int   start;
    logic found;
    found = 1'b0;
    wb(1'b1, LPVC_OFS_CTRL, 32'h17);
    start = cyc_cnt;
    repeat (pre) @(posedge clk_sys);
    while (!found && cyc_cnt - start < limit) begin
      wb(1'b0, LPVC_OFS_STAT, 32'h0);
      found = dec_set(q[7:0]);
      if (!found) repeat (MS) @(posedge clk_sys);
    end
    check(found, exp);
    while (cyc_cnt - start < SETTLE + 3) @(posedge clk_sys);
    wb(1'b0, LPVC_OFS_STAT, 32'h0);
    check(q, exp ? 32'h1F0 : 32'h10F);
  endtask

  // Flag only moves at measurement points one period apart
  task automatic t_period();
    int n;
    n = 0;
    fault <= 1'b1;
    while (vok !== 1'b0 && n < MEAS + 5) begin
      @(posedge clk_sys);
      n++;
    end
    check(n <= MEAS + 1, 1'b1);
    fault <= 1'b0;
    n = 0;
    while (vok !== 1'b1 && n < 2 * MEAS) begin
      @(posedge clk_sys);
      n++;
    end
    check(n >= MEAS - 1 && n <= MEAS + 1, 1'b1);
  endtask

  task automatic t_restore();
    wb(1'b1, LPVC_OFS_VOLT, 32'h00000589);
    settle2();
    check({pon, vok, code}, 32'h389);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_init();
    t_poll(0, 85 * MS, 1'b1);
    t_period();
    t_restore();
    t_off();
    t_poll(20 * MS, 65 * MS, 1'b1);
    t_off();
    fault <= 1'b1;
    t_poll(0, 85 * MS, 1'b0);
    finish_test();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    finish_test();
  end
endmodule // lpvc_top_test
